//--- hdl/btt_pkg.sv
// Package with register map, field layout and reset values of the bank timing trim bank
package btt_pkg;
  // Printed offsets are not all multiples of four: they are indices, byte address is 4x
  localparam logic [8:0] IDX_BANK0_TRIM_ZERO_PHASE = 9'h102;
  localparam logic [8:0] IDX_BANK0_TRIM_QUADRATURE = 9'h103;
  localparam logic [8:0] IDX_BANK1_TRIM_ZERO_PHASE = 9'h112;
  localparam logic [8:0] IDX_BANK1_TRIM_QUADRATURE = 9'h113;
  localparam logic [8:0] IDX_BANK4_TRIM_ZERO_PHASE = 9'h142;
  localparam logic [8:0] IDX_BANK5_TRIM_ZERO_PHASE = 9'h152;
  localparam logic [8:0] IDX_TIMESTAMP_OUTPUT_CONTROL = 9'h160;
  localparam logic [8:0] IDX_MODE_CONTROL = 9'h170;
  localparam logic [8:0] IDX_STATUS = 9'h171;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 9;
  localparam int TRIM_W = 8;
  localparam int TRIM_MSB = 7;
  localparam int TRIM_LSB = 0;
  localparam int NUM_TRIM = 6;
  localparam int FUSE_AW = 3;
  localparam logic [7:0] TS_CTRL_RESET = 8'h00;
  localparam int TS_EN_BIT = 0;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam int MODE_SINGLE_BIT = 0;
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_SINGLE_BIT = 1;
  localparam int STAT_TS_BIT = 2;
  localparam int TS_LATENCY = 4;
  localparam logic [7:0] FUSE_DEFAULT = 8'h80;
  typedef enum logic [1:0] {
    BTT_LOAD_ADDR,
    BTT_LOAD_WAIT,
    BTT_LOAD_TAKE,
    BTT_RUN
  } btt_load_state_t;
endpackage

//--- hdl/btt_fuse_rom.sv
// Factory fuse store holding the power-on trim words, with registered read data
`timescale 1ns/10ps
module btt_fuse_rom #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic [AW-1:0] addr_i,
  output logic [DW-1:0] data_o
);
  initial begin
    if (DEPTH > (1 << AW) || DW < 1) begin
      $error("btt_fuse_rom: bad geometry");
    end
  end

  logic [DW-1:0] mem [DEPTH];

  // Fuse contents stand as neutral defaults; a real part programs them at test
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = btt_pkg::FUSE_DEFAULT + DW'(i);
    end
  end

  always_ff @(posedge clk_i) begin
    data_o <= mem[addr_i];
  end
endmodule

//--- hdl/btt_ts_delay.sv
// Delay line that aligns the timestamp marker with the analog sample path
`timescale 1ns/10ps
module btt_ts_delay #(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_i,
  output logic out_o
);
  initial begin
    if (DEPTH < 1) begin
      $error("btt_ts_delay: depth must be at least one");
    end
  end

  logic [DEPTH-1:0] pipe_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_q <= '0;
    end else begin
      // Oldest stage drops off the top; also serves a one-stage line
      pipe_q <= DEPTH'({pipe_q, in_i});
    end
  end

  assign out_o = pipe_q[DEPTH-1];
endmodule

//--- hdl/btt_regs.sv
// Bank timing trim register bank with fuse load, phase selection and timestamp gate
`timescale 1ns/10ps
module btt_regs #(
  parameter int TS_DELAY = btt_pkg::TS_LATENCY,
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic timestamp_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic [SAMPLE_W-1:0] sample_o,
  output logic [7:0] bank0_trim_o,
  output logic [7:0] bank1_trim_o,
  output logic [7:0] bank4_trim_o,
  output logic [7:0] bank5_trim_o,
  output logic single_channel_o,
  output logic trims_loaded_o
);
  initial begin
    if (SAMPLE_W < 2 || TS_DELAY < 1) begin
      $error("btt_regs: unsupported parameters");
    end
  end

  localparam int NT = btt_pkg::NUM_TRIM;
  localparam int AW = btt_pkg::FUSE_AW;

  // Trim slots: 0 b0 zero, 1 b0 quad, 2 b1 zero, 3 b1 quad, 4 b4 zero, 5 b5 zero
  function automatic logic [AW:0] trim_slot(input logic [btt_pkg::IDX_W-1:0] idx);
    logic [AW:0] s;
    s = {1'b1, AW'(0)};
    case (idx)
      btt_pkg::IDX_BANK0_TRIM_ZERO_PHASE: s = {1'b0, AW'(0)};
      btt_pkg::IDX_BANK0_TRIM_QUADRATURE: s = {1'b0, AW'(1)};
      btt_pkg::IDX_BANK1_TRIM_ZERO_PHASE: s = {1'b0, AW'(2)};
      btt_pkg::IDX_BANK1_TRIM_QUADRATURE: s = {1'b0, AW'(3)};
      btt_pkg::IDX_BANK4_TRIM_ZERO_PHASE: s = {1'b0, AW'(4)};
      btt_pkg::IDX_BANK5_TRIM_ZERO_PHASE: s = {1'b0, AW'(5)};
      default: s = {1'b1, AW'(0)};
    endcase
    return s;
  endfunction

  logic [7:0] trim_q [NT];
  logic [7:0] ts_ctrl_q;
  logic [7:0] mode_ctrl_q;
  logic [AW-1:0] load_idx_q;
  logic [7:0] fuse_data;
  btt_pkg::btt_load_state_t load_st_q;
  logic loaded_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  logic ts_delayed;
  logic [btt_pkg::IDX_W-1:0] idx;
  logic [AW:0] slot;
  logic req;
  logic known;

  assign idx = wb_adr_i[btt_pkg::IDX_W+btt_pkg::ADDR_LSB-1:btt_pkg::ADDR_LSB];
  assign slot = trim_slot(idx);
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign known = !slot[AW] || idx == btt_pkg::IDX_TIMESTAMP_OUTPUT_CONTROL
    || idx == btt_pkg::IDX_MODE_CONTROL || idx == btt_pkg::IDX_STATUS;

  btt_fuse_rom #(
    .DEPTH(8),
    .AW(AW),
    .DW(8)
  ) u_fuse (
    .clk_i(clk_i),
    .addr_i(load_idx_q),
    .data_o(fuse_data)
  );

  // Fuse walk after reset; bus trim writes before it ends are acked but dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_st_q <= btt_pkg::BTT_LOAD_ADDR;
      load_idx_q <= '0;
      loaded_q <= 1'b0;
    end else begin
      case (load_st_q)
        btt_pkg::BTT_LOAD_ADDR: load_st_q <= btt_pkg::BTT_LOAD_WAIT;
        btt_pkg::BTT_LOAD_WAIT: load_st_q <= btt_pkg::BTT_LOAD_TAKE;
        btt_pkg::BTT_LOAD_TAKE: begin
          if (load_idx_q == AW'(NT - 1)) begin
            load_st_q <= btt_pkg::BTT_RUN;
            loaded_q <= 1'b1;
          end else begin
            load_idx_q <= load_idx_q + AW'(1);
            load_st_q <= btt_pkg::BTT_LOAD_WAIT;
          end
        end
        btt_pkg::BTT_RUN: load_st_q <= btt_pkg::BTT_RUN;
        default: load_st_q <= btt_pkg::BTT_LOAD_ADDR;
      endcase
    end
  end

  // Trim storage: fuse word during load, byte lane 0 writes after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NT; i++) begin
        trim_q[i] <= '0;
      end
    end else if (load_st_q == btt_pkg::BTT_LOAD_TAKE) begin
      trim_q[load_idx_q] <= fuse_data;
    end else if (req && wb_we_i && wb_sel_i[0] && !slot[AW] && loaded_q) begin
      trim_q[slot[AW-1:0]] <= wb_dat_i[btt_pkg::TRIM_MSB:btt_pkg::TRIM_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_ctrl_q <= btt_pkg::TS_CTRL_RESET;
    end else if (req && wb_we_i && wb_sel_i[0]
        && idx == btt_pkg::IDX_TIMESTAMP_OUTPUT_CONTROL) begin
      ts_ctrl_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ctrl_q <= btt_pkg::MODE_CTRL_RESET;
    end else if (req && wb_we_i && wb_sel_i[0] && idx == btt_pkg::IDX_MODE_CONTROL) begin
      mode_ctrl_q <= wb_dat_i[7:0];
    end
  end

  // Bus answer one cycle after the request; unmapped index answers with err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= req && known;
      err_q <= req && !known;
      rdat_q <= '0;
      if (req && !wb_we_i) begin
        if (!slot[AW]) begin
          rdat_q <= {24'h000000, trim_q[slot[AW-1:0]]};
        end else if (idx == btt_pkg::IDX_TIMESTAMP_OUTPUT_CONTROL) begin
          rdat_q <= {24'h000000, ts_ctrl_q};
        end else if (idx == btt_pkg::IDX_MODE_CONTROL) begin
          rdat_q <= {24'h000000, mode_ctrl_q};
        end else if (idx == btt_pkg::IDX_STATUS) begin
          rdat_q[btt_pkg::STAT_LOADED_BIT] <= loaded_q;
          rdat_q[btt_pkg::STAT_SINGLE_BIT] <= mode_ctrl_q[btt_pkg::MODE_SINGLE_BIT];
          rdat_q[btt_pkg::STAT_TS_BIT] <= ts_ctrl_q[btt_pkg::TS_EN_BIT];
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;

  // Phase selection for banks 0 and 1; registered so the analog trim never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank0_trim_o <= '0;
      bank1_trim_o <= '0;
      bank4_trim_o <= '0;
      bank5_trim_o <= '0;
      single_channel_o <= 1'b0;
    end else begin
      single_channel_o <= mode_ctrl_q[btt_pkg::MODE_SINGLE_BIT];
      if (mode_ctrl_q[btt_pkg::MODE_SINGLE_BIT]) begin
        bank0_trim_o <= trim_q[1];
        bank1_trim_o <= trim_q[3];
      end else begin
        bank0_trim_o <= trim_q[0];
        bank1_trim_o <= trim_q[2];
      end
      bank4_trim_o <= trim_q[4];
      bank5_trim_o <= trim_q[5];
    end
  end

  assign trims_loaded_o = loaded_q;

  // Marker path delayed to match the sample pipe below
  btt_ts_delay #(
    .DEPTH(TS_DELAY)
  ) u_ts (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i(timestamp_i),
    .out_o(ts_delayed)
  );

  logic [SAMPLE_W-1:0] spipe_q [TS_DELAY];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < TS_DELAY; i++) begin
        spipe_q[i] <= '0;
      end
    end else begin
      spipe_q[0] <= sample_i;
      for (int i = 1; i < TS_DELAY; i++) begin
        spipe_q[i] <= spipe_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o <= '0;
    end else if (ts_ctrl_q[btt_pkg::TS_EN_BIT]) begin
      sample_o <= {spipe_q[TS_DELAY-1][SAMPLE_W-1:1], ts_delayed};
    end else begin
      sample_o <= spipe_q[TS_DELAY-1];
    end
  end
endmodule

//--- test/btt_regs_monitor.sv
// Port checks for the bank timing trim register bank
`timescale 1ns/10ps
module btt_regs_monitor #(
  parameter int TS_DELAY = 4,
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic [SAMPLE_W-1:0] sample_o,
  input wire logic [7:0] bank4_trim_o,
  input wire logic single_channel_o,
  input wire logic trims_loaded_o
);
  // Cycles since reset, saturating; keeps pipeline checks off reset leftovers
  logic [3:0] up_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hf) begin
      up_q <= up_q + 4'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  answer_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o != wb_err_o) else $error("no single answer");
  answer_cause_a: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  read_idle_a: assert property ((!wb_ack_o || $past(wb_we_i)) |-> wb_dat_o == 32'h0)
    else $error("read data outside read ack");
  load_wait_a: assert property (up_q < 4'd10 |-> !trims_loaded_o)
    else $error("fuse load too early");
  load_done_a: assert property (up_q == 4'hf |-> trims_loaded_o)
    else $error("fuse load too late");
  loaded_hold_a: assert property (trims_loaded_o |=> trims_loaded_o) else $error("load lost");
  bank4_write_a: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0] && trims_loaded_o
    && wb_adr_i == 12'h508) |=> bank4_trim_o == $past(wb_dat_i[7:0], 2))
    else $error("bank 4 trim not applied");
  sample_path_a: assert property (up_q > TS_DELAY + 2
    |-> sample_o[SAMPLE_W-1:1] == $past(sample_i[SAMPLE_W-1:1], TS_DELAY + 1))
    else $error("sample path latency wrong");
  cover property (wb_ack_o && !$past(wb_we_i));
  cover property (wb_err_o);
  cover property ($rose(single_channel_o));
endmodule
bind btt_regs btt_regs_monitor #(.TS_DELAY(TS_DELAY), .SAMPLE_W(SAMPLE_W)) u_mon (.*);

//--- test/tb_btt_regs.sv
// Self-checking bench for the bank timing trim register bank
`timescale 1ns/10ps
module tb_btt_regs;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ts = 0, e, sc, ld, ack, err;
  logic [11:0] adr = 0, smp = 0, so;
  logic [31:0] dat = 0, q, dq;
  logic [3:0] sel = 4'h1;
  logic [7:0] t0, t1, t4, t5;
  int n_mismatch = 0, check_count = 0, i, n;
  logic [11:0] ta [6] = '{12'h408, 12'h40c, 12'h448, 12'h44c, 12'h508, 12'h548};
  always #2 clk_i = ~clk_i;
  btt_regs #(.TS_DELAY(4), .SAMPLE_W(12)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dq), .wb_ack_o(ack), .wb_err_o(err), .timestamp_i(ts),
    .sample_i(smp), .sample_o(so), .bank0_trim_o(t0), .bank1_trim_o(t1),
    .bank4_trim_o(t4), .bank5_trim_o(t5), .single_channel_o(sc), .trims_loaded_o(ld));
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, s, x);
    end
  endtask
  // Single classic cycle; ack sampled at the edge, so read data is taken there
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1 && err !== 1 && k < 20);
    q = dq;
    e = err;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (k >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 12'h580, 0);
    chk(q, 0);
    n = 0;
    while (ld !== 1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      n_mismatch++;
      close_out();
    end
    for (i = 0; i < 6; i++) begin
      wb(0, ta[i], 0);
      chk(q, 32'h80 + i);
    end
    chk({t0, t1, t4, t5}, 32'h80828485);
    wb(1, 12'h5c0, 1);
    repeat (3) @(posedge clk_i);
    chk({t0, t1, t4, t5}, 32'h81838485);
    for (i = 0; i < 6; i++) begin
      wb(1, ta[i], 32'hffffff30 + i);
      wb(0, ta[i], 0);
      chk(q, 32'h30 + i);
    end
    repeat (3) @(posedge clk_i);
    chk({t0, t1, t4, t5}, 32'h31333435);
    // Write with byte lane 0 off is acked but must leave the trim alone
    sel <= 4'h0;
    wb(1, ta[0], 32'h55);
    sel <= 4'h1;
    wb(0, ta[0], 0);
    chk(q, 32'h30);
    wb(1, 12'h5c0, 0);
    repeat (3) @(posedge clk_i);
    chk({t0, t1, t4, t5}, 32'h30323435);
    // Unmapped index must be refused
    wb(0, 12'h404, 0);
    chk(e, 1);
    wb(1, 12'h580, 1);
    wb(0, 12'h5c4, 0);
    chk(q, 32'h5);
    smp <= 12'hffe;
    ts <= 1;
    repeat (8) @(posedge clk_i);
    chk(so, 12'hfff);
    ts <= 0;
    repeat (8) @(posedge clk_i);
    chk(so, 12'hffe);
    wb(1, 12'h580, 0);
    ts <= 1;
    repeat (8) @(posedge clk_i);
    chk(so, 12'hffe);
    close_out();
  end
endmodule
